// *** core/pcf_pkg.sv ***
// Package: register map, mode codes and pad carrier for the port 4/5 pin configuration
package pcf_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [15:0] OFF_UP_CFG = 16'hb018;
   localparam logic [15:0] OFF_PE_CFG = 16'hb01c;
   localparam logic [15:0] OFF_UP_PD = 16'hb02c;
   localparam logic [15:0] OFF_PE_PU = 16'hb02d;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] RST_UP_CFG = 16'h0000;
   localparam logic [16:0] RST_PE_CFG = 17'h0_0000;
   localparam logic [7:0] RST_UP_PD = 8'hff;
   localparam logic [7:0] RST_PE_PU = 8'h00;
   // ----------------------------------------
   // Field positions and mode codes
   // ----------------------------------------
   localparam int RX_LSB = 12;
   localparam int TX_LSB = 14;
   localparam logic [1:0] MD_IN = 2'b00;
   localparam logic [1:0] MD_GPO = 2'b01;
   localparam logic [1:0] MD_ALT = 2'b10;
   localparam logic [1:0] MD_AUX = 2'b11;
   localparam logic [2:0] TX_IN = 3'b000;
   localparam logic [2:0] TX_GPO = 3'b001;
   localparam logic [2:0] TX_OD = 3'b011;
   localparam logic [2:0] TX_UPP = 3'b101;
   localparam logic [2:0] TX_UOD = 3'b111;
   // Pad carrier: output value and output enable per pin
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pcf_pad_t;
endpackage

// *** core/pcf_port_config.sv ***
// Pin configuration for the upper-address port and the peripheral port
`timescale 1ns/1ps
module pcf_port_config (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [15:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic [7:0] upPinIn,
   output pcf_pkg::pcf_pad_t upPad,
   output logic [7:0] upPullDown,
   input wire logic [7:0] upGpioOut,
   output logic [7:0] upGpioIn,
   input wire logic [7:0] extAddrHigh,
   input wire logic [7:0] extDataOut,
   input wire logic extDataOe,
   output logic [7:0] extDataIn,
   input wire logic [7:0] periphPinIn,
   output pcf_pkg::pcf_pad_t periphPad,
   output logic [7:0] periphPullUp,
   input wire logic [7:0] periphGpioOut,
   output logic [7:0] periphGpioIn,
   output logic extDmaRequestCh0N,
   output logic extDmaRequestCh1N,
   input wire logic dmaAckCh0N,
   input wire logic dmaAckCh1N,
   input wire logic i2cSdaDriveLow,
   input wire logic i2cSclDriveLow,
   output logic i2cSdaIn,
   output logic i2cSclIn,
   input wire logic uartEnable,
   input wire logic serialTransmitLine,
   output logic serialReceiveLine
);
   import pcf_pkg::*;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [15:0] upCfg;
   logic [16:0] peCfg;
   logic upCfgHit;
   logic peCfgHit;
   logic upPdHit;
   logic pePuHit;

   assign upCfgHit = regAddr == OFF_UP_CFG;
   assign peCfgHit = regAddr == OFF_PE_CFG;
   assign upPdHit = regAddr == OFF_UP_PD;
   assign pePuHit = regAddr == OFF_PE_PU;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         upCfg <= RST_UP_CFG;
         peCfg <= RST_PE_CFG;
      end else if (regWr) begin
         if (upCfgHit) begin
            upCfg <= regWdata[15:0];
         end
         if (peCfgHit) begin
            peCfg <= regWdata[16:0];
         end
      end
   end

   // Pull controls go straight to the pads, so the registers are the outputs
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         upPullDown <= RST_UP_PD;
         periphPullUp <= RST_PE_PU;
      end else if (regWr) begin
         if (upPdHit) begin
            upPullDown <= regWdata[7:0];
         end
         if (pePuHit) begin
            periphPullUp <= regWdata[7:0];
         end
      end
   end

   // Unmapped addresses read as zero; data stands one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         regRdata <= 32'h0000_0000;
      end else if (regRd) begin
         if (upCfgHit) begin
            regRdata <= {16'h0000, upCfg};
         end else if (peCfgHit) begin
            regRdata <= {15'h0000, peCfg};
         end else if (upPdHit) begin
            regRdata <= {24'h00_0000, upPullDown};
         end else if (pePuHit) begin
            regRdata <= {24'h00_0000, periphPullUp};
         end else begin
            regRdata <= 32'h0000_0000;
         end
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end

   sequence s_write(logic [15:0] off);
      regWr && regAddr == off;
   endsequence

   sequence s_read(logic [15:0] off);
      regRd && !regWr && regAddr == off;
   endsequence

   property p_resetVals;
      $fell(sys_rst) |-> upCfg == RST_UP_CFG && peCfg == RST_PE_CFG &&
         upPullDown == RST_UP_PD && periphPullUp == RST_PE_PU;
   endproperty
   a_resetVals: assert property (p_resetVals) else $error("Bad reset values");

   property p_cfgReadBack;
      logic [15:0] v;
      (s_write(OFF_UP_CFG), v = regWdata[15:0]) ##1 s_read(OFF_UP_CFG)
         |=> regRdata == {16'h0000, v};
   endproperty
   a_cfgReadBack: assert property (p_cfgReadBack) else $error("Readback wrong");

   property p_pullWrite;
      s_write(OFF_UP_PD) |=> upPullDown == $past(regWdata[7:0]);
   endproperty
   a_pullWrite: assert property (p_pullWrite) else $error("Pull-down not stored");

   // ----------------------------------------
   // Upper-address port pin muxing
   // ----------------------------------------
   logic [7:0] next_upOut;
   logic [7:0] next_upOe;
   logic [7:0] next_dataIn;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_up
         logic [1:0] mode;
         assign mode = upCfg[2*gi +: 2];
         assign next_upOe[gi] = (mode == MD_GPO) || (mode == MD_ALT) ||
            ((mode == MD_AUX) && extDataOe);
         assign next_upOut[gi] = (mode == MD_GPO) ? upGpioOut[gi] :
            (mode == MD_ALT) ? extAddrHigh[gi] :
            (mode == MD_AUX) ? extDataOut[gi] : 1'b0;
         assign next_dataIn[gi] = (mode == MD_AUX) ? upPinIn[gi] : 1'b0;
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         upPad <= '0;
         extDataIn <= 8'h00;
         upGpioIn <= 8'h00;
      end else begin
         upPad.out <= next_upOut;
         upPad.oe <= next_upOe;
         extDataIn <= next_dataIn;
         upGpioIn <= upPinIn;
      end
   end

   property p_upGpo;
      upCfg[1:0] == MD_GPO |=> upPad.oe[0] && upPad.out[0] == $past(upGpioOut[0]);
   endproperty
   a_upGpo: assert property (p_upGpo) else $error("Pin 0 not push-pull");

   property p_upAddr;
      upCfg[15:14] == MD_ALT |=> upPad.oe[7] && upPad.out[7] == $past(extAddrHigh[7]);
   endproperty
   a_upAddr: assert property (p_upAddr) else $error("Address bit 23 not driven");

   property p_upData;
      upCfg[3:2] == MD_AUX |=> upPad.oe[1] == $past(extDataOe) &&
         extDataIn[1] == $past(upPinIn[1]);
   endproperty
   a_upData: assert property (p_upData) else $error("Data bit 9 not routed");

   // ----------------------------------------
   // Peripheral port pin muxing
   // ----------------------------------------
   logic [7:0] next_peOut;
   logic [7:0] next_peOe;
   logic [1:0] next_dreqN;
   logic next_sda;
   logic next_scl;
   logic next_rx;
   logic [1:0] rxMode;
   logic [2:0] txMode;
   logic [1:0] ackN;

   assign rxMode = peCfg[RX_LSB +: 2];
   assign txMode = peCfg[TX_LSB +: 3];
   assign ackN = {dmaAckCh1N, dmaAckCh0N};

   // Open-drain pins only ever drive low: out held 0, enable carries the inverted level
   always_comb begin
      next_peOut = 8'h00;
      next_peOe = 8'h00;
      next_dreqN = 2'b11;
      next_sda = 1'b1;
      next_scl = 1'b1;
      next_rx = 1'b1;
      for (int p = 0; p < 6; p++) begin
         if (peCfg[2*p +: 2] == MD_GPO) begin
            next_peOut[p] = periphGpioOut[p];
            next_peOe[p] = 1'b1;
         end
      end
      for (int c = 0; c < 2; c++) begin
         if (peCfg[4*c +: 2] == MD_ALT) begin
            next_dreqN[c] = periphPinIn[2*c];
         end
         if (peCfg[4*c+2 +: 2] == MD_ALT) begin
            next_peOut[2*c+1] = ackN[c];
            next_peOe[2*c+1] = 1'b1;
         end
      end
      if (peCfg[9:8] == MD_ALT) begin
         next_peOe[4] = i2cSdaDriveLow;
         next_sda = periphPinIn[4];
      end
      if (peCfg[11:10] == MD_ALT) begin
         next_peOe[5] = i2cSclDriveLow;
         next_scl = periphPinIn[5];
      end
      case (rxMode)
         MD_IN: next_rx = uartEnable ? periphPinIn[6] : 1'b1;
         MD_GPO: begin
            next_peOut[6] = periphGpioOut[6];
            next_peOe[6] = 1'b1;
         end
         MD_ALT: next_peOe[6] = !periphGpioOut[6];
         default: ;
      endcase
      case (txMode)
         TX_GPO: begin
            next_peOut[7] = periphGpioOut[7];
            next_peOe[7] = 1'b1;
         end
         TX_OD: next_peOe[7] = !periphGpioOut[7];
         TX_UPP: begin
            next_peOut[7] = serialTransmitLine;
            next_peOe[7] = 1'b1;
         end
         TX_UOD: next_peOe[7] = !serialTransmitLine;
         default: ;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         periphPad <= '0;
         periphGpioIn <= 8'h00;
         extDmaRequestCh0N <= 1'b1;
         extDmaRequestCh1N <= 1'b1;
         i2cSdaIn <= 1'b1;
         i2cSclIn <= 1'b1;
         serialReceiveLine <= 1'b1;
      end else begin
         periphPad.out <= next_peOut;
         periphPad.oe <= next_peOe;
         periphGpioIn <= periphPinIn;
         extDmaRequestCh0N <= next_dreqN[0];
         extDmaRequestCh1N <= next_dreqN[1];
         i2cSdaIn <= next_sda;
         i2cSclIn <= next_scl;
         serialReceiveLine <= next_rx;
      end
   end

   // ----------------------------------------
   // Peripheral port checks
   // ----------------------------------------

   property p_dmaReq;
      peCfg[5:4] == MD_ALT |=> extDmaRequestCh1N == $past(periphPinIn[2]);
   endproperty
   a_dmaReq: assert property (p_dmaReq) else $error("DMA request 1 not routed");

   property p_dmaAck;
      peCfg[3:2] == MD_ALT |=> periphPad.oe[1] && periphPad.out[1] == $past(dmaAckCh0N);
   endproperty
   a_dmaAck: assert property (p_dmaAck) else $error("DMA acknowledge 0 not driven");

   property p_sdaOd;
      peCfg[9:8] == MD_ALT |=> !periphPad.out[4] &&
         periphPad.oe[4] == $past(i2cSdaDriveLow);
   endproperty
   a_sdaOd: assert property (p_sdaOd) else $error("Data line not open-drain");

   property p_rxGate;
      rxMode == MD_IN && !uartEnable |=> serialReceiveLine;
   endproperty
   a_rxGate: assert property (p_rxGate) else $error("Receive not gated");

   property p_txOd;
      txMode == TX_UOD |=> !periphPad.out[7] && periphPad.oe[7] == !$past(serialTransmitLine);
   endproperty
   a_txOd: assert property (p_txOd) else $error("Transmit not open-drain");

   property p_txIn;
      txMode == TX_IN || txMode == 3'b010 |=> !periphPad.oe[7];
   endproperty
   a_txIn: assert property (p_txIn) else $error("Pin 7 driven as input");

endmodule // pcf_port_config

// *** verification/pcf_pad_partner.sv ***
// Far-side model: pads, pull resistors and outside drivers of both ports
`timescale 1ns/1ps
module pcf_pad_partner (
   input wire logic clk_sys,
   input wire pcf_pkg::pcf_pad_t upPad,
   input wire pcf_pkg::pcf_pad_t periphPad,
   input wire logic [7:0] upPullDown,
   input wire logic [7:0] periphPullUp,
   input wire logic [15:0] extDrive,
   input wire logic [15:0] extEn,
   output logic [7:0] upPinIn,
   output logic [7:0] periphPinIn
);
   import pcf_pkg::*;
   logic [15:0] noise = 16'h5a5a;
   // Floating pins wander every cycle so a stale level never passes for a driven one
   always @(posedge clk_sys) noise <= ~noise;
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         upPinIn[n] = upPad.oe[n] ? upPad.out[n] : extEn[n] ? extDrive[n] :
            upPullDown[n] ? 1'b0 : noise[n];
         periphPinIn[n] = periphPad.oe[n] ? periphPad.out[n] : extEn[n+8] ? extDrive[n+8] :
            periphPullUp[n] ? 1'b1 : noise[n+8];
      end
   end
endmodule // pcf_pad_partner

// *** verification/pcf_port_config_test.sv ***
// Self-checking bench for the port 4/5 pin configuration block
`timescale 1ns/1ps
module pcf_port_config_test;
   import pcf_pkg::*;
   logic clk_sys = 0, sys_rst = 1, regWr = 0, regRd = 0, extDataOe = 0;
   logic dmaAckCh0N = 1, dmaAckCh1N = 1, i2cSdaDriveLow = 0, i2cSclDriveLow = 0;
   logic uartEnable = 0, serialTransmitLine = 1;
   logic [15:0] regAddr = '0, extDrive = '0, extEn = '0;
   logic [31:0] regWdata = '0, regRdata, seed = 32'h0001_66df;
   logic [7:0] upGpioOut = '0, extAddrHigh = '0, extDataOut = '0, periphGpioOut = '0;
   logic [7:0] upPinIn, periphPinIn, upPullDown, periphPullUp, upGpioIn, periphGpioIn;
   logic [7:0] extDataIn, prevUp, prevPe;
   logic extDmaRequestCh0N, extDmaRequestCh1N, i2cSdaIn, i2cSclIn, serialReceiveLine;
   pcf_pad_t upPad, periphPad;
   int errors = 0, checksDone = 0;
   logic [31:0] rdExp = '0;
   logic rdDue = 0;
   logic [15:0] offs [5] = '{OFF_UP_CFG, OFF_PE_CFG, OFF_UP_PD, OFF_PE_PU, 16'hb030};
   logic [31:0] msk [5] = '{32'h0000_ffff, 32'h0001_ffff, 32'h0000_00ff, 32'h0000_00ff,
      32'h0000_0000};
   logic [31:0] shadow [5] = '{32'(RST_UP_CFG), 32'(RST_PE_CFG), 32'(RST_UP_PD),
      32'(RST_PE_PU), 32'h0000_0000};

   pcf_port_config i_pcf_port_config (.clk_sys, .sys_rst, .regAddr, .regWdata, .regWr,
      .regRd, .regRdata, .upPinIn, .upPad, .upPullDown, .upGpioOut, .upGpioIn,
      .extAddrHigh, .extDataOut, .extDataOe, .extDataIn, .periphPinIn, .periphPad,
      .periphPullUp, .periphGpioOut, .periphGpioIn, .extDmaRequestCh0N, .extDmaRequestCh1N,
      .dmaAckCh0N, .dmaAckCh1N, .i2cSdaDriveLow, .i2cSclDriveLow, .i2cSdaIn, .i2cSclIn,
      .uartEnable, .serialTransmitLine, .serialReceiveLine);
   pcf_pad_partner i_pcf_pad_partner (.clk_sys, .upPad, .periphPad, .upPullDown,
      .periphPullUp, .extDrive, .extEn, .upPinIn, .periphPinIn);

   initial forever #25 clk_sys = ~clk_sys;
   // Pin levels as the block sampled them at the last edge
   always @(posedge clk_sys) begin
      prevUp <= upPinIn;
      prevPe <= periphPinIn;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   task automatic conclude();
      if (errors == 0 && checksDone > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input int r, input logic [31:0] d);
      regRd <= 0;
      regWr <= 1;
      regAddr <= offs[r];
      regWdata <= d;
      shadow[r] = d & msk[r];
      @(posedge clk_sys);
   endtask

   task automatic rd(input int r);
      regWr <= 0;
      regRd <= 1;
      regAddr <= offs[r];
      @(posedge clk_sys);
      rdExp <= shadow[r];
   endtask

   // Read data stand only in the cycle after the strobe, so look mid-cycle
   always @(posedge clk_sys) rdDue <= regRd;
   always @(negedge clk_sys) begin
      if (!sys_rst) chk(regRdata, rdDue ? rdExp : 32'h0000_0000);
   end

   function automatic logic [15:0] expUp();
      logic [7:0] o, e;
      logic [1:0] c;
      for (int n = 0; n < 8; n++) begin
         c = shadow[0][2*n +: 2];
         e[n] = c == MD_GPO || c == MD_ALT || (c == MD_AUX && extDataOe);
         o[n] = e[n] & (c == MD_GPO ? upGpioOut[n] : c == MD_ALT ? extAddrHigh[n] :
            extDataOut[n]);
      end
      return {o, e};
   endfunction

   function automatic logic [15:0] expPe();
      logic [7:0] o, e, g;
      logic [1:0] c;
      logic [2:0] t;
      g = periphGpioOut;
      for (int n = 0; n < 6; n++) begin
         c = shadow[1][2*n +: 2];
         e[n] = c == MD_GPO || (c == MD_ALT && (n == 1 || n == 3 ||
            (n == 4 && i2cSdaDriveLow) || (n == 5 && i2cSclDriveLow)));
         o[n] = e[n] & (c == MD_GPO ? g[n] : n == 1 ? dmaAckCh0N : n == 3 & dmaAckCh1N);
      end
      c = shadow[1][13:12];
      e[6] = c == MD_GPO || (c == MD_ALT && !g[6]);
      o[6] = c == MD_GPO && g[6];
      t = shadow[1][16:14];
      e[7] = t == TX_GPO || t == TX_UPP || (t == TX_OD && !g[7]) ||
         (t == TX_UOD && !serialTransmitLine);
      o[7] = (t == TX_GPO && g[7]) || (t == TX_UPP && serialTransmitLine);
      return {o, e};
   endfunction

   task automatic check();
      logic [7:0] xd;
      logic [1:0] c6;
      c6 = shadow[1][13:12];
      for (int n = 0; n < 8; n++) xd[n] = shadow[0][2*n +: 2] == MD_AUX && prevUp[n];
      chk({upPad.out & upPad.oe, upPad.oe}, expUp());
      chk(extDataIn, xd);
      chk(upGpioIn, prevUp);
      chk(upPullDown, shadow[2]);
      chk(periphPullUp, shadow[3]);
      chk({periphPad.out & periphPad.oe, periphPad.oe}, expPe());
      chk(periphGpioIn, prevPe);
      chk({extDmaRequestCh0N, extDmaRequestCh1N, i2cSdaIn, i2cSclIn, serialReceiveLine},
         {shadow[1][1:0] != MD_ALT || prevPe[0], shadow[1][5:4] != MD_ALT || prevPe[2],
         shadow[1][9:8] != MD_ALT || prevPe[4], shadow[1][11:10] != MD_ALT || prevPe[5],
         !(c6 == MD_IN && uartEnable) || prevPe[6]});
   endtask

   task automatic stim();
      logic [31:0] a, b;
      a = rnd();
      b = rnd();
      {upGpioOut, extAddrHigh, extDataOut, periphGpioOut} <= a;
      {extDataOe, dmaAckCh0N, dmaAckCh1N, i2cSdaDriveLow, i2cSclDriveLow, uartEnable,
         serialTransmitLine} <= b[6:0];
      extDrive <= b[31:16];
      extEn <= b[22:7];
      regWr <= 0;
      regRd <= 0;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      check();
      @(posedge clk_sys);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      check();
      @(posedge clk_sys);
      for (int r = 0; r < 5; r++) rd(r);
      // Back-to-back writes of all ones, then reads with no gap
      for (int r = 0; r < 5; r++) wr(r, 32'hffff_ffff);
      for (int r = 0; r < 5; r++) rd(r);
      for (int i = 0; i < 300; i++) begin
         // Writes end on the first register so the very next read sees the new value
         for (int r = 4; r >= 0; r--) wr(r, rnd());
         for (int r = 0; r < 5; r++) rd(r);
         stim();
      end
      conclude();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      conclude();
   end
endmodule // pcf_port_config_test
